// [cic_pkg.sv]
// constants for the core identity and capability register bank
// assumes a core-side special-register port: address, read/write strobes, mode flag
package cic_pkg;
  // special-register indices of the bank
  localparam logic [15:0] ADDR_LEGACY_ID = 16'h0000;
  localparam logic [15:0] ADDR_UNIT_PRESENCE = 16'h0001;
  localparam logic [15:0] ADDR_CORE_CAP = 16'h0002;
  // legacy identity field positions
  localparam int STEP_LSB = 0;
  localparam int STEP_W = 6;
  localparam int NEWER_ID_BIT = 6;
  localparam int TEMPLATE_LSB = 16;
  localparam int FAMILY_LSB = 24;
  localparam logic [7:0] TEMPLATE_LIMIT = 8'h32;
  // legal family range; both ends are arbitrary
  localparam logic [7:0] FAMILY_MIN = 8'h20;
  localparam logic [7:0] FAMILY_MAX = 8'h2F;
  // unit presence bit positions
  localparam int UP_SELF = 0;
  localparam int UP_DCACHE = 1;
  localparam int UP_ICACHE = 2;
  localparam int UP_DXLAT = 3;
  localparam int UP_IXLAT = 4;
  localparam int UP_MAC = 5;
  localparam int UP_DEBUG = 6;
  localparam int UP_PERF = 7;
  localparam int UP_POWER = 8;
  localparam int UP_IRQ = 9;
  localparam int UP_TICK = 10;
  localparam int UP_CUSTOM_LSB = 24;
  // core capability bit positions
  localparam int CC_SHADOW_LSB = 0;
  localparam int CC_REDUCED_RF = 4;
  localparam int CC_BRANCH_SKIP = 10;
  localparam int CC_ARCH_REL = 11;
  localparam int CC_VEC_BASE = 12;
  localparam int CC_VENDOR = 13;
  localparam int CC_ARITH_EXC = 14;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  typedef enum logic [1:0] {SEL_NONE, SEL_ID, SEL_UNIT, SEL_CAP} cic_sel_t;
endpackage

// [cic_value_latch.sv]
// one read-only word held in flip-flops, loaded with its fixed value
// assumes value is a constant tied by the parent
`timescale 1ns/10ps
`default_nettype none
module cic_value_latch
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [31:0] value,
  output logic [31:0] word
);
  logic [31:0] word_reg;
  logic [31:0] word_next;

  // value is loaded after reset release, never under the asynchronous reset
  always_comb
  begin
    word_next = value;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      word_reg <= cic_pkg::RESET_VALUE;
    else
      word_reg <= word_next;
  end

  assign word = word_reg;
endmodule
`default_nettype wire

// [cic_identity_regs.sv]
// identity, unit presence and core capability registers of the core
// assumes a core pipeline that issues special-register moves with a supervisor flag
`timescale 1ns/10ps
`default_nettype none
module cic_identity_regs
#(
  parameter logic [7:0] FAMILY_CODE = 8'h20, // arbitrary
  parameter logic [5:0] STEPPING = 6'h01, // arbitrary, bump per revision
  parameter logic [7:0] TEMPLATE = 8'h00,
  parameter bit HAS_CONFIG_REGS = 1'b1,
  parameter bit NEWER_ID = 1'b1,
  parameter logic [10:1] UNITS = 10'h000,
  parameter logic [7:0] CUSTOM_UNITS = 8'h00,
  parameter logic [3:0] SHADOW_FILES = 4'h0,
  parameter int GPR_COUNT = 32,
  parameter bit BRANCH_SKIP = 1'b0,
  parameter bit ARCH_REL_REG = 1'b1,
  parameter bit VEC_BASE_REG = 1'b0,
  parameter bit VENDOR_REGS = 1'b0,
  parameter bit ARITH_EXC_REGS = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [15:0] sprAddr,
  input wire logic sprRead,
  input wire logic sprWrite,
  input wire logic [31:0] sprWdata,
  input wire logic supervisorMode,
  output logic [31:0] sprRdata,
  output logic sprHit,
  output logic sprDenied
);
  logic [31:0] idValue;
  logic [31:0] unitValue;
  logic [31:0] capValue;
  logic [31:0] idWord;
  logic [31:0] unitWord;
  logic [31:0] capWord;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  cic_pkg::cic_sel_t sel;

  function automatic cic_pkg::cic_sel_t decode(input logic [15:0] a);
    if (a == cic_pkg::ADDR_LEGACY_ID)
      decode = cic_pkg::SEL_ID;
    else if (a == cic_pkg::ADDR_UNIT_PRESENCE)
      decode = cic_pkg::SEL_UNIT;
    else if (a == cic_pkg::ADDR_CORE_CAP)
      decode = cic_pkg::SEL_CAP;
    else
      decode = cic_pkg::SEL_NONE;
  endfunction

  // template forced onto the correct side of 50 so a bad parameter cannot lie
  function automatic logic [7:0] fixTemplate(input logic [7:0] t, input bit cfg);
    if (cfg && t >= cic_pkg::TEMPLATE_LIMIT)
      fixTemplate = cic_pkg::TEMPLATE_LIMIT - 8'h01;
    else if (!cfg && t < cic_pkg::TEMPLATE_LIMIT)
      fixTemplate = cic_pkg::TEMPLATE_LIMIT;
    else
      fixTemplate = t;
  endfunction

  function automatic logic [7:0] fixFamily(input logic [7:0] f);
    if (f < cic_pkg::FAMILY_MIN)
      fixFamily = cic_pkg::FAMILY_MIN;
    else if (f > cic_pkg::FAMILY_MAX)
      fixFamily = cic_pkg::FAMILY_MAX;
    else
      fixFamily = f;
  endfunction

  always_comb
  begin
    idValue = 32'h0000_0000; // reserved bits read zero
    idValue[cic_pkg::STEP_LSB +: cic_pkg::STEP_W] = STEPPING;
    idValue[cic_pkg::NEWER_ID_BIT] = NEWER_ID;
    idValue[cic_pkg::TEMPLATE_LSB +: 8] = fixTemplate(TEMPLATE, HAS_CONFIG_REGS);
    idValue[cic_pkg::FAMILY_LSB +: 8] = fixFamily(FAMILY_CODE);
  end

  always_comb
  begin
    unitValue = 32'h0000_0000;
    unitValue[cic_pkg::UP_SELF] = 1'b1;
    unitValue[cic_pkg::UP_TICK:cic_pkg::UP_DCACHE] = UNITS;
    unitValue[cic_pkg::UP_CUSTOM_LSB +: 8] = CUSTOM_UNITS;
  end

  always_comb
  begin
    capValue = 32'h0000_0000;
    capValue[cic_pkg::CC_SHADOW_LSB +: 4] = SHADOW_FILES;
    capValue[cic_pkg::CC_REDUCED_RF] = (GPR_COUNT < 32);
    capValue[cic_pkg::CC_BRANCH_SKIP] = BRANCH_SKIP;
    capValue[cic_pkg::CC_ARCH_REL] = ARCH_REL_REG;
    capValue[cic_pkg::CC_VEC_BASE] = VEC_BASE_REG;
    capValue[cic_pkg::CC_VENDOR] = VENDOR_REGS;
    capValue[cic_pkg::CC_ARITH_EXC] = ARITH_EXC_REGS;
  end

  cic_value_latch u_id
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .value(idValue),
    .word(idWord)
  );

  cic_value_latch u_unit
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .value(unitValue),
    .word(unitWord)
  );

  cic_value_latch u_cap
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .value(capValue),
    .word(capWord)
  );

  assign sel = decode(sprAddr);
  // write data is accepted and dropped; nothing here stores it
  assign sprHit = (sel != cic_pkg::SEL_NONE) && (sprRead || sprWrite);
  assign sprDenied = sprHit && !supervisorMode;

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (sprRead && supervisorMode)
    begin
      case (sel)
        cic_pkg::SEL_ID: rdata_next = idWord;
        cic_pkg::SEL_UNIT: rdata_next = unitWord;
        cic_pkg::SEL_CAP: rdata_next = capWord;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= cic_pkg::RESET_VALUE;
    else
      rdata_reg <= rdata_next;
  end

  assign sprRdata = rdata_reg;

  logic unused;
  assign unused = ^sprWdata;

  property p_user_read_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    (sprRead && !supervisorMode) |=> (sprRdata == 32'h0000_0000);
  endproperty
  a_user_read_zero: assert property (p_user_read_zero) else $error("user read leaked data");

  property p_denied;
    @(posedge sys_clk) disable iff (!arst_n)
    sprDenied |-> (sprHit && !supervisorMode);
  endproperty
  a_denied: assert property (p_denied) else $error("denied flag wrong");

  property p_id_read;
    @(posedge sys_clk) disable iff (!arst_n)
    (sprRead && supervisorMode && sel == cic_pkg::SEL_ID && $past(arst_n))
      |=> (sprRdata[15:7] == 9'h000) && (sprRdata[23:16] == $past(idWord[23:16]))
        && (sprRdata[cic_pkg::NEWER_ID_BIT] == NEWER_ID)
        && (sprRdata[5:0] == STEPPING);
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity read wrong");

  property p_template;
    @(posedge sys_clk) disable iff (!arst_n)
    $past(arst_n) |-> ((idWord[23:16] < cic_pkg::TEMPLATE_LIMIT) == HAS_CONFIG_REGS);
  endproperty
  a_template: assert property (p_template) else $error("template range wrong");

  property p_family;
    @(posedge sys_clk) disable iff (!arst_n)
    $past(arst_n) |-> (idWord[31:24] >= cic_pkg::FAMILY_MIN && idWord[31:24] <= cic_pkg::FAMILY_MAX);
  endproperty
  a_family: assert property (p_family) else $error("family code out of range");

  property p_unit_reserved;
    @(posedge sys_clk) disable iff (!arst_n)
    $past(arst_n) |-> (unitWord[23:11] == 13'h0000) && unitWord[0];
  endproperty
  a_unit_reserved: assert property (p_unit_reserved) else $error("presence word wrong");

  property p_reduced_rf;
    @(posedge sys_clk) disable iff (!arst_n)
    $past(arst_n) |-> (capWord[4] == (GPR_COUNT < 32));
  endproperty
  a_reduced_rf: assert property (p_reduced_rf) else $error("register file flag wrong");

  property p_write_no_effect;
    @(posedge sys_clk) disable iff (!arst_n)
    ($past(arst_n) && sprWrite) |=> $stable(idWord) && $stable(unitWord) && $stable(capWord);
  endproperty
  a_write_no_effect: assert property (p_write_no_effect) else $error("write changed a word");

  c_id_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
    sprRead && supervisorMode && sel == cic_pkg::SEL_ID);
  c_cap_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
    sprRead && supervisorMode && sel == cic_pkg::SEL_CAP);
  c_denied: cover property (@(posedge sys_clk) disable iff (!arst_n) sprDenied);
endmodule
`default_nettype wire

// [cic_identity_regs_tb.sv]
// self-checking bench for the identity, presence and capability word bank
// assumes the bank's special-register port and package; stimulus 2 ns after each rising edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module cic_identity_regs_tb;
  typedef struct packed
  {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic sup;
    logic hit;
    logic den;
    logic [31:0] data;
  } cic_row_t;
  // default family 20, template 00, newer flag, stepping 01
  localparam logic [31:0] ID_WORD = 32'h2000_0041;
  // custom C3, units 2A5 shifted up one, self bit set
  localparam logic [31:0] UNIT_WORD = 32'hC300_054B;
  // shadow F, reduced file, skip slot, release register by default
  localparam logic [31:0] CAP_WORD = 32'h0000_0C1F;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] sprAddr = 16'h0000;
  logic sprRead = 1'b0;
  logic sprWrite = 1'b0;
  logic [31:0] sprWdata = 32'h0000_0000;
  logic supervisorMode = 1'b0;
  logic [31:0] sprRdata;
  logic sprHit;
  logic sprDenied;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  cic_row_t rows [0:7];
  // only five settings moved off their defaults; the rest run as shipped
  cic_identity_regs #(.UNITS(10'h2A5), .CUSTOM_UNITS(8'hC3), .SHADOW_FILES(4'hF),
    .GPR_COUNT(16), .BRANCH_SKIP(1'b1)) i_cic_identity_regs
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sprAddr(sprAddr),
    .sprRead(sprRead),
    .sprWrite(sprWrite),
    .sprWdata(sprWdata),
    .supervisorMode(supervisorMode),
    .sprRdata(sprRdata),
    .sprHit(sprHit),
    .sprDenied(sprDenied)
  );
  always #25 sys_clk = ~sys_clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the few dozen cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      test_done();
    end
  end
  // entered 2 ns after an edge; leaves 2 ns after the answering edge
  task automatic access(input cic_row_t r);
    sprAddr = r.addr;
    sprRead = r.rd;
    sprWrite = r.wr;
    sprWdata = 32'hFFFF_FFFF;
    supervisorMode = r.sup;
    #1;
    `CHK("hit", r.hit, sprHit)
    `CHK("denied", r.den, sprDenied)
    @(posedge sys_clk);
    #2;
    `CHK("rdata", r.data, sprRdata)
  endtask
  task automatic idle();
    sprRead = 1'b0;
    sprWrite = 1'b0;
    @(posedge sys_clk);
    #2;
  endtask
  initial
  begin
    rows[0] = '{16'h0000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, ID_WORD};
    rows[1] = '{16'h0001, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, UNIT_WORD};
    rows[2] = '{16'h0002, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, CAP_WORD};
    rows[3] = '{16'h0003, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0000};
    rows[4] = '{16'h0000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0000};
    rows[5] = '{16'h0002, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 32'h0000_0000};
    rows[6] = '{16'h0002, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, CAP_WORD};
    rows[7] = '{16'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 32'h0000_0000};
    repeat (3) @(posedge sys_clk);
    #2;
    `CHK("rdata in reset", 32'h0000_0000, sprRdata)
    arst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2;
    // back to back, no idle cycle between rows
    for (int i = 0; i < 7; i++)
      access(rows[i]);
    $display("table test done");
    // answer stands one cycle only
    access(rows[1]);
    idle();
    `CHK("rdata after idle", 32'h0000_0000, sprRdata)
    // user-mode write then supervisor read of the same word
    access(rows[7]);
    access(rows[0]);
    idle();
    $display("stand and write test done");
    // a live answer must vanish as soon as reset lands
    sprAddr = 16'h0001;
    sprRead = 1'b1;
    supervisorMode = 1'b1;
    @(posedge sys_clk);
    #2;
    `CHK("rdata before reset", UNIT_WORD, sprRdata)
    arst_n = 1'b0;
    #1;
    `CHK("rdata mid reset", 32'h0000_0000, sprRdata)
    @(posedge sys_clk);
    #2;
    `CHK("rdata held reset", 32'h0000_0000, sprRdata)
    arst_n = 1'b1;
    // words reload at the first edge after release, so wait two
    idle();
    idle();
    access(rows[1]);
    access(rows[2]);
    idle();
    $display("reset test done");
    test_done();
  end
endmodule
`default_nettype wire
